/* rtl/adcc_defs.svh */
// Register map, field positions, reset values and timing counts of the converter control bank.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define ADCC_IX_CTRL_A   6'h00
`define ADCC_IX_CTRL_B   6'h01
`define ADCC_IX_CTRL_C   6'h02
`define ADCC_IX_CTRL_D   6'h03
`define ADCC_IX_CTRL_E   6'h04
`define ADCC_IX_SAMPLE_LENGTH  6'h05
`define ADCC_IX_MUX      6'h06
`define ADCC_IX_CMD      6'h08
`define ADCC_IX_EVCTL    6'h09
`define ADCC_IX_IRQ_EN   6'h0a
`define ADCC_IX_IRQ_FLAG 6'h0b
`define ADCC_IX_DBG      6'h0c
`define ADCC_IX_HOLD     6'h0d
`define ADCC_IX_RES_LO   6'h10
`define ADCC_IX_RES_HI   6'h11
`define ADCC_IX_WLO_LO   6'h12
`define ADCC_IX_WLO_HI   6'h13
`define ADCC_IX_WHI_LO   6'h14
`define ADCC_IX_WHI_HI   6'h15
`define ADCC_IX_CALIBRATION    6'h16
// ----------------------------------------------------------------------
// Field positions and writable-bit masks.
// ----------------------------------------------------------------------
`define ADCC_B_ENABLE    0
`define ADCC_B_RESOLUTION_SELECT    2
`define ADCC_B_STANDBY_RUN   7
`define ADCC_B_CAP       6
`define ADCC_B_AUTO_DELAY_VARIATION      4
`define ADCC_B_FRDY      0
`define ADCC_B_FWIN      1
`define ADCC_WM_CTRL_A   8'h85
`define ADCC_WM_CTRL_C   8'h77
`define ADCC_WM_3BIT     8'h07
`define ADCC_WM_5BIT     8'h1f
`define ADCC_WM_2BIT     8'h03
`define ADCC_WM_1BIT     8'h01
`define ADCC_RST_BYTE    8'h00
// ----------------------------------------------------------------------
// Timing counts in converter-clock cycles.
// ----------------------------------------------------------------------
`define ADCC_PIPE        9'h00b
`define ADCC_SH_MIN      9'h002
`define ADCC_SETTLE_UNIT 9'h008
`endif

/* rtl/adcc_pkg.sv */
// Types shared by the converter control bank.
package adcc_pkg;
   // Sequencer states of the converter.
   typedef enum logic [2:0] {ST_OFF, ST_INIT, ST_IDLE, ST_CONV, ST_GAP} adcc_state_t;

   // Whole state of the block in one record.
   typedef struct packed {
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
      logic [7:0]  ctrl_c;
      logic [7:0]  ctrl_d;
      logic [7:0]  ctrl_e;
      logic [7:0]  samp_ctl;
      logic [7:0]  mux;
      logic [7:0]  ev_ctl;
      logic [7:0]  irq_en;
      logic [7:0]  irq_flag;
      logic [7:0]  dbg;
      logic [7:0]  hold;
      logic [7:0]  calibration;
      logic [15:0] res;
      logic [15:0] win_lo;
      logic [15:0] win_hi;
      logic [1:0]  ref_act;
      logic [4:0]  mux_act;
      logic        busy;
      logic        ev_last;
      logic        was_on;
      logic [7:0]  div_cnt;
      logic [8:0]  cnt;
      logic [6:0]  smp_left;
      logic [15:0] acc;
      logic [7:0]  rdata;
      adcc_state_t st;
   } adcc_regs_t;
endpackage

/* rtl/adcc_top.sv */
// Control and configuration register bank of a 10-bit sampling converter.
//
// Notes on behaviour
// - Standby stops converter unless run-in-standby set.
// - Resolution bit one drops two lowest bits.
// - Enable bit gates the whole converter.
// - Accumulate 1 to 64 samples per conversion.
// - Capacitance bit selects reduced sampling capacitor.
// - Reference code 0 internal, 1 supply.
// - New reference applies only between conversions.
// - Converter clock is peripheral clock over 2^(n+1).
// - Settling delay 0 to 256 cycles on start.
// - Initial delay adds eleven pipeline cycles.
// - Auto variation bumps sampling delay each sample.
// - Auto variation wraps delay field to zero.
// - Sampling delay 0 to 15 cycles between samples.
// - Window compare result against two thresholds.
// - Start bit reads one until conversion ends.
// - Each sample takes hold cycles plus eleven.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_top (
   // Clock and reset.
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // APB slave.
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // System and event inputs.
   input  wire logic        STANDBY,
   input  wire logic        START_EVENT,
   // Converter core.
   input  wire logic [9:0]  ADC_DATA,
   output logic             ADC_ON,
   output logic             ADC_TICK,
   output logic             ADC_TAKE,
   output logic             CAP_SMALL,
   output logic [1:0]       REF_SEL,
   output logic [4:0]       MUX_SEL,
   // Interrupt.
   output logic             IRQ
);
   import adcc_pkg::*;

   // ----------------------------------------------------------------------
   // State and decode.
   // ----------------------------------------------------------------------
   adcc_regs_t  q_reg;                     // Registered state.
   adcc_regs_t  q_next;                    // Next state.
   logic [5:0]  idx;                       // Word index of the bus address.
   logic        wr;                        // Write completes this edge.
   logic        rd_setup;                  // Read setup phase.
   logic        map_ok;                    // Address hits a register.
   logic [7:0]  rd_byte;                   // Read data mux output.
   logic        on;                        // Converter clock may run.
   logic [8:0]  div_max;                   // Prescaler terminal count.
   logic        tick;                      // One converter-clock period.
   logic [15:0] smp_val;                   // Sample after resolution cut.
   logic [15:0] acc_sum;                   // Accumulator plus new sample.
   logic        take;                      // Sample taken this cycle.
   logic        done;                      // Last sample of a conversion.
   logic        win_hit;                   // Window condition on result.
   logic [8:0]  settle;                    // Programmed settling delay.
   logic [8:0]  conv_len;                  // Cycles of one sample, less one.
   logic [6:0]  smp_total;                 // Samples per conversion, less one.
   logic        ev_rise;                   // Rising edge of the event input.
   logic [7:0]  flag_set;                  // Hardware flag set this cycle.

   assign idx      = PADDR[7:2];
   assign wr       = PSEL && PENABLE && PWRITE;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;

   // Standby freezes the clock divider unless run-in-standby is set.
   assign on = q_reg.ctrl_a[`ADCC_B_ENABLE] &&
               (!STANDBY || q_reg.ctrl_a[`ADCC_B_STANDBY_RUN]);

   // Terminal count gives division by 2, 4 .. 256.
   assign div_max = (`ADCC_SH_MIN << q_reg.ctrl_c[2:0]) - 9'h001;
   assign tick    = on && (q_reg.div_cnt == div_max[7:0]);

   // In 8-bit mode the two lowest converter bits are dropped.
   assign smp_val = q_reg.ctrl_a[`ADCC_B_RESOLUTION_SELECT] ? {8'h00, ADC_DATA[9:2]}
                                                 : {6'h00, ADC_DATA};
   assign acc_sum = q_reg.acc + smp_val;
   assign take    = tick && (q_reg.st == ST_CONV) && (q_reg.cnt == 9'h000);
   assign done    = take && (q_reg.smp_left == 7'h00);
   assign ev_rise = START_EVENT && !q_reg.ev_last;

   // Sample length plus the fixed pipeline, counted down to zero.
   assign conv_len = {4'h0, q_reg.samp_ctl[4:0]} + `ADCC_SH_MIN + `ADCC_PIPE
                     - 9'h001;

   // Reserved accumulation code 7 falls back to a single sample.
   assign smp_total = (q_reg.ctrl_b[2:0] > 3'h6) ? 7'h00
                      : ((7'h01 << q_reg.ctrl_b[2:0]) - 7'h01);

   // ----------------------------------------------------------------------
   // Settling delay and window comparison.
   // ----------------------------------------------------------------------
   // Reserved settling codes behave as no extra delay.
   always_comb begin
      if (q_reg.ctrl_d[7:5] == 3'h0 || q_reg.ctrl_d[7:5] > 3'h5) begin
         settle = 9'h000;
      end else begin
         settle = `ADCC_SETTLE_UNIT << q_reg.ctrl_d[7:5];
      end
   end

   // Compared against the final accumulated value, once per conversion.
   always_comb begin
      unique case (q_reg.ctrl_e[2:0])
         3'h1:    win_hit = acc_sum < q_reg.win_lo;
         3'h2:    win_hit = acc_sum > q_reg.win_hi;
         3'h3:    win_hit = (acc_sum > q_reg.win_lo) && (acc_sum < q_reg.win_hi);
         3'h4:    win_hit = !((acc_sum > q_reg.win_lo) && (acc_sum < q_reg.win_hi));
         default: win_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Read data mux.
   // ----------------------------------------------------------------------
   // Unmapped words answer zero with an error; unused bits are stored as zero.
   always_comb begin
      map_ok  = (PADDR[1:0] == 2'b00);
      rd_byte = 8'h00;
      unique case (idx)
         `ADCC_IX_CTRL_A:   rd_byte = q_reg.ctrl_a;
         `ADCC_IX_CTRL_B:   rd_byte = q_reg.ctrl_b;
         `ADCC_IX_CTRL_C:   rd_byte = q_reg.ctrl_c;
         `ADCC_IX_CTRL_D:   rd_byte = q_reg.ctrl_d;
         `ADCC_IX_CTRL_E:   rd_byte = q_reg.ctrl_e;
         `ADCC_IX_SAMPLE_LENGTH:  rd_byte = q_reg.samp_ctl;
         `ADCC_IX_MUX:      rd_byte = q_reg.mux;
         `ADCC_IX_CMD:      rd_byte = {7'h00, q_reg.busy};
         `ADCC_IX_EVCTL:    rd_byte = q_reg.ev_ctl;
         `ADCC_IX_IRQ_EN:   rd_byte = q_reg.irq_en;
         `ADCC_IX_IRQ_FLAG: rd_byte = q_reg.irq_flag;
         `ADCC_IX_DBG:      rd_byte = q_reg.dbg;
         `ADCC_IX_HOLD:     rd_byte = q_reg.hold;
         `ADCC_IX_RES_LO:   rd_byte = q_reg.res[7:0];
         `ADCC_IX_RES_HI:   rd_byte = q_reg.hold;
         `ADCC_IX_WLO_LO:   rd_byte = q_reg.win_lo[7:0];
         `ADCC_IX_WLO_HI:   rd_byte = q_reg.hold;
         `ADCC_IX_WHI_LO:   rd_byte = q_reg.win_hi[7:0];
         `ADCC_IX_WHI_HI:   rd_byte = q_reg.hold;
         `ADCC_IX_CALIBRATION:    rd_byte = q_reg.calibration;
         default:           map_ok  = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------------
   always_comb begin
      q_next          = q_reg;
      flag_set        = 8'h00;
      q_next.ev_last  = START_EVENT;
      q_next.was_on   = q_reg.ctrl_a[`ADCC_B_ENABLE];
      q_next.div_cnt  = tick ? 8'h00 : (on ? q_reg.div_cnt + 8'h01 : q_reg.div_cnt);

      // A read latches its byte in setup; a low-byte read snapshots the high byte.
      if (rd_setup) begin
         q_next.rdata = rd_byte;
         if (idx == `ADCC_IX_RES_LO) begin
            q_next.hold = q_reg.res[15:8];
         end else if (idx == `ADCC_IX_WLO_LO) begin
            q_next.hold = q_reg.win_lo[15:8];
         end else if (idx == `ADCC_IX_WHI_LO) begin
            q_next.hold = q_reg.win_hi[15:8];
         end
      end

      // Writes land at the access edge, masked to the writable bits.
      if (wr && map_ok) begin
         unique case (idx)
            `ADCC_IX_CTRL_A:  q_next.ctrl_a   = PWDATA[7:0] & `ADCC_WM_CTRL_A;
            `ADCC_IX_CTRL_B:  q_next.ctrl_b   = PWDATA[7:0] & `ADCC_WM_3BIT;
            `ADCC_IX_CTRL_C:  q_next.ctrl_c   = PWDATA[7:0] & `ADCC_WM_CTRL_C;
            `ADCC_IX_CTRL_D:  q_next.ctrl_d   = PWDATA[7:0];
            `ADCC_IX_CTRL_E:  q_next.ctrl_e   = PWDATA[7:0] & `ADCC_WM_3BIT;
            `ADCC_IX_SAMPLE_LENGTH: q_next.samp_ctl = PWDATA[7:0] & `ADCC_WM_5BIT;
            `ADCC_IX_MUX:     q_next.mux      = PWDATA[7:0] & `ADCC_WM_5BIT;
            `ADCC_IX_CMD: begin
               // Writing zero does nothing; a one starts only when enabled.
               if (PWDATA[0] && q_reg.ctrl_a[`ADCC_B_ENABLE]) begin
                  q_next.busy = 1'b1;
               end
            end
            `ADCC_IX_EVCTL:   q_next.ev_ctl   = PWDATA[7:0] & `ADCC_WM_1BIT;
            `ADCC_IX_IRQ_EN:  q_next.irq_en   = PWDATA[7:0] & `ADCC_WM_2BIT;
            `ADCC_IX_DBG:     q_next.dbg      = PWDATA[7:0] & `ADCC_WM_1BIT;
            `ADCC_IX_HOLD:    q_next.hold     = PWDATA[7:0];
            `ADCC_IX_WLO_LO:  q_next.hold     = PWDATA[7:0];
            `ADCC_IX_WLO_HI:  q_next.win_lo   = {PWDATA[7:0], q_reg.hold};
            `ADCC_IX_WHI_LO:  q_next.hold     = PWDATA[7:0];
            `ADCC_IX_WHI_HI:  q_next.win_hi   = {PWDATA[7:0], q_reg.hold};
            `ADCC_IX_CALIBRATION:   q_next.calibration    = PWDATA[7:0] & `ADCC_WM_1BIT;
            default:          q_next.rdata    = q_reg.rdata;
         endcase
      end

      // An enabled event edge starts a conversion like the command bit.
      if (ev_rise && q_reg.ev_ctl[0] && q_reg.ctrl_a[`ADCC_B_ENABLE]) begin
         q_next.busy = 1'b1;
      end

      // Sequencer.
      unique case (q_reg.st)
         ST_OFF: begin
            if (q_reg.ctrl_a[`ADCC_B_ENABLE] && q_reg.was_on) begin
               q_next.st  = ST_INIT;
               q_next.cnt = settle + `ADCC_PIPE - 9'h001;
            end
         end
         ST_INIT: begin
            if (tick && q_reg.cnt == 9'h000) begin
               q_next.st = ST_IDLE;
            end else if (tick) begin
               q_next.cnt = q_reg.cnt - 9'h001;
            end
         end
         ST_IDLE: begin
            // Selections follow software only between conversions.
            q_next.mux_act = q_reg.mux[4:0];
            if (q_reg.ctrl_c[5:4] != q_reg.ref_act) begin
               q_next.ref_act = q_reg.ctrl_c[5:4];
               q_next.st      = ST_INIT;
               q_next.cnt     = settle + `ADCC_PIPE - 9'h001;
            end else if (q_reg.busy) begin
               q_next.st       = ST_CONV;
               q_next.cnt      = conv_len;
               q_next.acc      = 16'h0000;
               q_next.smp_left = smp_total;
            end
         end
         ST_CONV: begin
            if (take) begin
               q_next.acc      = acc_sum;
               q_next.smp_left = q_reg.smp_left - 7'h01;
               if (q_reg.ctrl_d[`ADCC_B_AUTO_DELAY_VARIATION]) begin
                  q_next.ctrl_d[3:0] = q_reg.ctrl_d[3:0] + 4'h1;
               end
               if (done) begin
                  q_next.res  = acc_sum;
                  q_next.busy = 1'b0;
                  q_next.st   = ST_IDLE;
                  flag_set[`ADCC_B_FRDY] = 1'b1;
                  flag_set[`ADCC_B_FWIN] = win_hit;
               end else if (q_reg.ctrl_d[3:0] == 4'h0) begin
                  q_next.cnt = conv_len;
               end else begin
                  q_next.st  = ST_GAP;
                  q_next.cnt = {5'h00, q_reg.ctrl_d[3:0]} - 9'h001;
               end
            end else if (tick) begin
               q_next.cnt = q_reg.cnt - 9'h001;
            end
         end
         ST_GAP: begin
            if (tick && q_reg.cnt == 9'h000) begin
               q_next.st  = ST_CONV;
               q_next.cnt = conv_len;
            end else if (tick) begin
               q_next.cnt = q_reg.cnt - 9'h001;
            end
         end
      endcase

      // Disabling stops everything and drops a pending start.
      if (!q_reg.ctrl_a[`ADCC_B_ENABLE]) begin
         q_next.st   = ST_OFF;
         q_next.busy = 1'b0;
      end

      // Flags clear on writing one; a hardware set in the same cycle wins.
      q_next.irq_flag = q_reg.irq_flag | flag_set;
      if (wr && map_ok && idx == `ADCC_IX_IRQ_FLAG) begin
         q_next.irq_flag = (q_reg.irq_flag & ~(PWDATA[7:0] & `ADCC_WM_2BIT)) | flag_set;
      end
   end

   // ----------------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         q_reg          <= '0;
         q_reg.st       <= ST_OFF;
         q_reg.ctrl_a   <= `ADCC_RST_BYTE;
      end else begin
         q_reg <= q_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------------
   assign PREADY    = 1'b1;
   assign PSLVERR   = PSEL && PENABLE && !map_ok;
   assign PRDATA    = {24'h000000, q_reg.rdata};
   assign ADC_ON    = on;
   assign ADC_TICK  = tick;
   assign ADC_TAKE  = take;
   assign CAP_SMALL = q_reg.ctrl_c[`ADCC_B_CAP];
   assign REF_SEL   = q_reg.ref_act;
   assign MUX_SEL   = q_reg.mux_act;
   assign IRQ       = |(q_reg.irq_flag & q_reg.irq_en);

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   standby_stop_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      STANDBY && !q_reg.ctrl_a[`ADCC_B_STANDBY_RUN]
      |-> !tick ##1 q_reg.div_cnt == $past(q_reg.div_cnt))
      else $error("Converter clock ran in standby.");
   disable_off_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      !q_reg.ctrl_a[`ADCC_B_ENABLE] |=> q_reg.st == ST_OFF && !q_reg.busy)
      else $error("Converter active while disabled.");
   res_cut_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      take && q_reg.ctrl_a[`ADCC_B_RESOLUTION_SELECT]
      |=> q_reg.acc == $past(q_reg.acc) + {8'h00, $past(ADC_DATA[9:2])})
      else $error("Sample not cut to eight bits.");
   div2_rate_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      tick && q_reg.ctrl_c[2:0] == 3'h0 ##1 on && q_reg.ctrl_c[2:0] == 3'h0
      ##1 on && q_reg.ctrl_c[2:0] == 3'h0 |-> tick && !$past(tick))
      else $error("Divide-by-two tick spacing wrong.");
   init_load_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      q_next.st == ST_INIT && q_reg.st != ST_INIT |=> q_reg.cnt == settle + 9'h00a)
      else $error("Initial delay count wrong.");
   conv_load_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      q_reg.st == ST_IDLE && q_next.st == ST_CONV
      |=> q_reg.cnt == {4'h0, q_reg.samp_ctl[4:0]} + 9'h00c)
      else $error("Sample length count wrong.");
   ref_freeze_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      q_reg.st == ST_CONV || q_reg.st == ST_GAP |=> $stable(q_reg.ref_act))
      else $error("Reference changed during a conversion.");
   delay_step_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      take && q_reg.ctrl_d[`ADCC_B_AUTO_DELAY_VARIATION]
      |=> q_reg.ctrl_d[3:0] == $past(q_reg.ctrl_d[3:0]) + 4'h1)
      else $error("Sampling delay not stepped.");
   done_flag_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      done |=> !q_reg.busy && q_reg.irq_flag[`ADCC_B_FRDY] && q_reg.res == $past(acc_sum))
      else $error("Completion not reported.");
   gap_len_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
      take && !done && q_reg.ctrl_d[3:0] != 4'h0
      |=> q_reg.st == ST_GAP && q_reg.cnt == $past({5'h00, q_reg.ctrl_d[3:0]}) - 9'h001)
      else $error("Sampling gap length wrong.");
endmodule

/* dv/tb.sv */
// Self-checking testbench of the converter control bank.
`timescale 1ns/1ps

module tb;
   // ---------------------------------------------------------------
   // Stimulus and observed signals.
   // ---------------------------------------------------------------
   logic        clk_sys  = 1'b0;
   logic        srst     = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic        standby  = 1'b0;
   logic [9:0]  adc_data = 10'h2a7;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        adc_on;
   logic        adc_tick;
   logic        start_event = 1'b0;
   logic        adc_take;
   logic        cap_small;
   logic [1:0]  ref_sel;
   logic [4:0]  mux_sel;
   logic        irq;
   logic [31:0] rdat;
   logic        err;
   int          n_errors = 0;
   int          checked  = 0;
   int          n_take   = 0;

   // Clock at 250 MHz.
   always #2 clk_sys = ~clk_sys;

   adcc_top u_adcc_top (
      .CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .STANDBY(standby), .START_EVENT(start_event), .ADC_DATA(adc_data), .ADC_ON(adc_on),
      .ADC_TICK(adc_tick), .ADC_TAKE(adc_take), .CAP_SMALL(cap_small), .REF_SEL(ref_sel),
      .MUX_SEL(mux_sel), .IRQ(irq));

   // Samples taken by the converter, counted over the whole run.
   always @(posedge clk_sys) begin
      if (adc_take === 1'b1) begin
         n_take <= n_take + 1;
      end
   end

   // ---------------------------------------------------------------
   // Bus and comparison helpers.
   // ---------------------------------------------------------------
   // One APB transfer; the answer is taken at the edge that sees pready.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // Only the watchdog ends a wait that never sees the answer.
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rdat = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Compare and count; a mismatch is reported at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   // Cycles from one converter tick to the next.
   task automatic tick_period(input int exp);
      int c;
      c = 0;
      while (adc_tick !== 1'b1 && c < 600) begin
         c++;
         @(posedge clk_sys);
      end
      c = 0;
      do begin
         @(posedge clk_sys);
         c++;
      end while (adc_tick !== 1'b1 && c < 600);
      chk(c, exp);
   endtask

   // ---------------------------------------------------------------
   // Scenarios.
   // ---------------------------------------------------------------
   // Only writable bits stick; a hole in the map errors and reads zero.
   task automatic t_regs();
      rd_chk(8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'hff);
      rd_chk(8'h08, 32'h77);
      apb(1'b1, 8'h10, 32'hff);
      rd_chk(8'h10, 32'h07);
      apb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rdat, 32'h0);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h10, 32'h0);
      $display("test regs done");
   endtask

   // The converter clock divides by two to the power of code plus one.
   task automatic t_div();
      apb(1'b1, 8'h00, 32'h1);
      tick_period(2);
      apb(1'b1, 8'h08, 32'h02);
      tick_period(8);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      $display("test divider done");
   endtask

   // Two accumulated samples with delay variation wrapping from 0xf.
   // The 8-bit run is started by an event edge instead of the command bit.
   task automatic t_conv(input logic res8, input logic [15:0] exp);
      int n;
      int base;
      n    = 0;
      base = n_take;
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h0c, 32'h1f);
      apb(1'b1, 8'h18, 32'h05);
      apb(1'b1, 8'h28, 32'h1);
      apb(1'b1, 8'h00, {29'h0, res8, 2'b01});
      if (res8) begin
         apb(1'b1, 8'h24, 32'h1);
         start_event <= 1'b1;
      end else begin
         apb(1'b1, 8'h20, 32'h1);
      end
      rd_chk(8'h20, 32'h1);
      while (rdat !== 32'h0 && n < 300) begin
         n++;
         apb(1'b0, 8'h20, 32'h0);
      end
      chk(rdat, 32'h0);
      chk(n_take - base, 2);
      rd_chk(8'h40, {24'h0, exp[7:0]});
      rd_chk(8'h44, {24'h0, exp[15:8]});
      rd_chk(8'h0c, 32'h11);
      rd_chk(8'h2c, 32'h1);
      chk({27'h0, mux_sel}, 32'h5);
      chk({31'h0, irq}, 32'h1);
      start_event <= 1'b0;
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h28, 32'h0);
      // The write lands at the edge the task returns on; look one edge later.
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h28, 32'h1);
      apb(1'b1, 8'h2c, 32'h1);
      @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      rd_chk(8'h2c, 32'h0);
      // A new reference is taken over from idle one cycle after the write.
      apb(1'b1, 8'h08, 32'h50);
      repeat (2) @(posedge clk_sys);
      chk({30'h0, ref_sel}, 32'h1);
      chk({31'h0, cap_small}, 32'h1);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      $display("test conversion done");
   endtask

   // Standby stops the converter unless run-in-standby is set.
   task automatic t_standby();
      apb(1'b1, 8'h00, 32'h1);
      @(posedge clk_sys);
      chk({31'h0, adc_on}, 32'h1);
      standby <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk({31'h0, adc_on}, 32'h0);
      apb(1'b1, 8'h00, 32'h81);
      @(posedge clk_sys);
      chk({31'h0, adc_on}, 32'h1);
      apb(1'b1, 8'h00, 32'h80);
      @(posedge clk_sys);
      chk({31'h0, adc_on}, 32'h0);
      standby <= 1'b0;
      $display("test standby done");
   endtask

   // ---------------------------------------------------------------
   // Verdict, the single place where the run ends.
   // ---------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watchdog: the tests need a few thousand cycles at most.
   initial begin
      #100000;
      n_errors++;
      results();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      t_regs();
      t_div();
      t_conv(1'b0, 16'h054e);
      t_conv(1'b1, 16'h0152);
      t_standby();
      results();
   end
endmodule
